// ---- hdl/kww_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module kww_core
    import kww_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control side
    kww_core_if.core  cif
);
    logic [7:0]  presc_ff;
    logic [11:0] count_ff;
    logic [11:0] nxt_count;
    logic        running_ff;
    logic        expired_ff;

    wire  [8:0]  factor     = kww_div_factor(cif.div_sel);
    wire         presc_wrap = (presc_ff == 8'(factor - 9'h001));
    wire         dec        = presc_wrap & running_ff;
    wire         hit_zero   = dec & (count_ff == 12'h001);

    // refresh beats start beats counting; a second start is harmless
    assign nxt_count = cif.refresh                 ? cif.reload_val :
                       (cif.start & ~running_ff)   ? KWW_CNT_INIT   :
                       (dec & count_ff == 12'h000) ? cif.reload_val :
                       dec                         ? count_ff - 12'h001 :
                                                     count_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_ff   <= 8'h00;
            count_ff   <= KWW_CNT_INIT;
            running_ff <= 1'b0;
            expired_ff <= 1'b0;
        end else begin
            presc_ff   <= presc_wrap ? 8'h00 : presc_ff + 8'h01;
            count_ff   <= nxt_count;
            running_ff <= running_ff | cif.start | cif.hw_run;
            expired_ff <= hit_zero & ~cif.refresh;
        end
    end

    assign cif.tick    = presc_wrap;
    assign cif.count   = count_ff;
    assign cif.running = running_ff;
    assign cif.expired = expired_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tick_period: assert property (presc_wrap |=> !presc_wrap [*3])
        else $error("prescaler tick closer than four cycles");
    a_count_zero: assert property (hit_zero && !cif.refresh |=> count_ff == 12'h000 && expired_ff)
        else $error("expiry not flagged at zero");
    a_idle_hold: assert property (!running_ff && !cif.start && !cif.refresh && !cif.hw_run
                                  |=> $stable(count_ff))
        else $error("counter moved while stopped");

endmodule // kww_core
`default_nettype wire

// ---- hdl/kww_core_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface kww_core_if;
    logic        start;
    logic        refresh;
    logic        hw_run;
    logic [2:0]  div_sel;
    logic [11:0] reload_val;
    logic        tick;
    logic [11:0] count;
    logic        running;
    logic        expired;

    modport ctrl (output start, refresh, hw_run, div_sel, reload_val,
                  input  tick, count, running, expired);
    modport core (input  start, refresh, hw_run, div_sel, reload_val,
                  output tick, count, running, expired);
endinterface
`default_nettype wire

// ---- hdl/kww_pkg.sv ----
package kww_pkg;

    localparam int          KWW_AW        = 12;
    localparam int          KWW_CNT_W     = 12;
    localparam int          KWW_NCFG      = 3;

    // register byte offsets
    localparam logic [11:0] KWW_OFF_KEY   = 12'h000;
    localparam logic [11:0] KWW_OFF_DIV   = 12'h004;
    localparam logic [11:0] KWW_OFF_RLD   = 12'h008;
    localparam logic [11:0] KWW_OFF_STS   = 12'h00c;
    localparam logic [11:0] KWW_OFF_WIN   = 12'h010;

    // command key words
    localparam logic [15:0] KWW_KEY_UNLOCK  = 16'h5555;
    localparam logic [15:0] KWW_KEY_REFRESH = 16'haaaa;
    localparam logic [15:0] KWW_KEY_START   = 16'hcccc;

    // reset values, window-off code and divider mask
    localparam logic [11:0] KWW_RST_DIV   = 12'h000;
    localparam logic [11:0] KWW_RST_RLD   = 12'hfff;
    localparam logic [11:0] KWW_RST_WIN   = 12'hfff;
    localparam logic [11:0] KWW_CNT_INIT  = 12'hfff;
    localparam logic [11:0] KWW_WIN_OFF   = 12'hfff;
    localparam logic [2:0]  KWW_DIV_MASK  = 3'h7;

    // status bit positions, also index of the config slot
    localparam int          KWW_STS_DIV   = 0;
    localparam int          KWW_STS_RLD   = 1;
    localparam int          KWW_STS_WIN   = 2;

    typedef logic [11:0] kww_cfg_t;

    function automatic logic [8:0] kww_div_factor(input logic [2:0] sel);
        logic [8:0] f;
        f = 9'h100;
        unique case (sel)
            3'h0: f = 9'h004;
            3'h1: f = 9'h008;
            3'h2: f = 9'h010;
            3'h3: f = 9'h020;
            3'h4: f = 9'h040;
            3'h5: f = 9'h080;
            3'h6: f = 9'h100;
            3'h7: f = 9'h100;
        endcase
        return f;
    endfunction

endpackage

// ---- hdl/kww_regs.sv ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module kww_regs
    import kww_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system
    input  wire logic        standby_rst,
    input  wire logic        hw_wdt_en,
    output var  logic        wdt_reset_req
);
    kww_core_if cif ();

    kww_core u_core (
        .pclk    (pclk),
        .presetn (presetn),
        .cif     (cif)
    );

    logic            unlock_ff;
    logic            hw_en_ff;
    logic [2:0]      pend_ff;
    logic [2:0]      arm_ff;
    kww_cfg_t        req_ff [KWW_NCFG];
    kww_cfg_t        act_ff [KWW_NCFG];
    logic [31:0]     prdata_ff;
    logic            rst_req_ff;
    logic [31:0]     nxt_prdata;

    // address decode
    wire             sel_key  = (paddr == KWW_OFF_KEY);
    wire             sel_div  = (paddr == KWW_OFF_DIV);
    wire             sel_rld  = (paddr == KWW_OFF_RLD);
    wire             sel_sts  = (paddr == KWW_OFF_STS);
    wire             sel_win  = (paddr == KWW_OFF_WIN);
    wire             hit      = sel_key | sel_div | sel_rld | sel_sts | sel_win;
    wire             setup    = psel & ~penable;
    wire             access   = psel & penable;
    // writes need both low byte lanes, so byte-wide writes are dropped, even those to the 3-bit divider
    wire             wr_ok    = access & pwrite & hit & (pstrb[1:0] == 2'b11);
    wire [15:0]      key_val  = pwdata[15:0];
    wire             key_wr   = wr_ok & sel_key;
    wire             key_unl  = key_wr & (key_val == KWW_KEY_UNLOCK);
    wire             key_ref  = key_wr & (key_val == KWW_KEY_REFRESH);
    wire             key_go   = key_wr & (key_val == KWW_KEY_START);

    // a config write counts only when unlocked and its own slot has nothing in flight
    wire [2:0]       sel_cfg  = {sel_win, sel_rld, sel_div};
    wire [2:0]       cfg_wr   = {3{wr_ok & unlock_ff}} & sel_cfg & ~pend_ff;
    wire             win_xfer = pend_ff[KWW_STS_WIN] & arm_ff[KWW_STS_WIN] & cif.tick;
    wire             win_on   = (act_ff[KWW_STS_WIN] != KWW_WIN_OFF);
    wire             early    = key_ref & cif.running & win_on
                                & (cif.count > act_ff[KWW_STS_WIN]);

    assign cif.start      = key_go;
    assign cif.refresh    = key_ref | win_xfer;
    assign cif.hw_run     = hw_en_ff;
    assign cif.div_sel    = act_ff[KWW_STS_DIV][2:0] & KWW_DIV_MASK;
    assign cif.reload_val = act_ff[KWW_STS_RLD];

    // lock and hardware option
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_ff <= 1'b0;
            hw_en_ff  <= 1'b0;
        end else begin
            if (standby_rst) begin
                unlock_ff <= 1'b0;
            end else if (key_wr) begin
                unlock_ff <= key_unl;
            end
            hw_en_ff  <= hw_en_ff | hw_wdt_en;
        end
    end

    // config slots: request side, pending flag, counter side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 3'h0;
            arm_ff  <= 3'h0;
            req_ff[KWW_STS_DIV] <= KWW_RST_DIV;
            req_ff[KWW_STS_RLD] <= KWW_RST_RLD;
            req_ff[KWW_STS_WIN] <= KWW_RST_WIN;
            act_ff[KWW_STS_DIV] <= KWW_RST_DIV;
            act_ff[KWW_STS_RLD] <= KWW_RST_RLD;
            act_ff[KWW_STS_WIN] <= KWW_RST_WIN;
        end else begin
            for (int i = 0; i < KWW_NCFG; i++) begin
                if (cfg_wr[i]) begin
                    pend_ff[i] <= 1'b1;
                    req_ff[i]  <= (i == KWW_STS_DIV) ? {9'h000, pwdata[2:0]} : pwdata[11:0];
                end else if (pend_ff[i] && cif.tick) begin
                    // two slow ticks, as a resynchroniser into the slow side takes
                    if (arm_ff[i]) begin
                        pend_ff[i] <= 1'b0;
                        arm_ff[i]  <= 1'b0;
                        act_ff[i]  <= req_ff[i];
                    end else begin
                        arm_ff[i]  <= 1'b1;
                    end
                end
            end
            if (standby_rst) begin
                // status survives; reload and window return home
                req_ff[KWW_STS_RLD] <= KWW_RST_RLD;
                req_ff[KWW_STS_WIN] <= KWW_RST_WIN;
                act_ff[KWW_STS_RLD] <= KWW_RST_RLD;
                act_ff[KWW_STS_WIN] <= KWW_RST_WIN;
            end
        end
    end

    // read mux, sampled in setup so data is ready in the access cycle
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (sel_div) nxt_prdata = {29'h0, act_ff[KWW_STS_DIV][2:0]};
        if (sel_rld) nxt_prdata = {20'h0, act_ff[KWW_STS_RLD]};
        if (sel_sts) nxt_prdata = {29'h0, pend_ff};
        if (sel_win) nxt_prdata = {20'h0, act_ff[KWW_STS_WIN]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            rst_req_ff <= 1'b0;
        end else begin
            if (setup && !pwrite) prdata_ff <= nxt_prdata;
            rst_req_ff <= (cif.expired | early) & ~rst_req_ff;
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = 1'b1;
    assign pslverr       = access & ~hit;
    assign wdt_reset_req = rst_req_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_key_reads_zero: assert property (setup && !pwrite && sel_key |=> prdata == 32'h0)
        else $error("key register read not zero");
    a_unlock_opens: assert property (key_unl && !standby_rst |=> unlock_ff)
        else $error("unlock key did not open");
    a_other_relocks: assert property (key_wr && !key_unl |=> !unlock_ff)
        else $error("other key left unlocked");
    a_locked_ignored: assert property (wr_ok && sel_rld && !unlock_ff && !standby_rst && !pend_ff[KWW_STS_RLD]
                                       |=> $stable(req_ff[KWW_STS_RLD]) && !pend_ff[KWW_STS_RLD])
        else $error("locked reload write took effect");
    a_pend_blocks: assert property (wr_ok && sel_div && pend_ff[KWW_STS_DIV] && !cif.tick
                                    |=> $stable(req_ff[KWW_STS_DIV]))
        else $error("divider changed while pending");
    a_flag_sets: assert property (cfg_wr[KWW_STS_WIN] |=> pend_ff[KWW_STS_WIN] ##[1:520] !pend_ff[KWW_STS_WIN])
        else $error("window flag did not set then clear");
    a_rld_flag: assert property (cfg_wr[KWW_STS_RLD] |=> pend_ff[KWW_STS_RLD])
        else $error("reload flag not set");
    a_div_flag: assert property (pend_ff[KWW_STS_DIV] && arm_ff[KWW_STS_DIV] && cif.tick
                                 |=> !pend_ff[KWW_STS_DIV] && act_ff[KWW_STS_DIV] == $past(req_ff[KWW_STS_DIV]))
        else $error("divider flag cleared without transfer");
    a_refresh_load: assert property (key_ref |=> cif.count == $past(act_ff[KWW_STS_RLD]))
        else $error("refresh did not load reload value");
    a_win_reload: assert property (win_xfer && !key_ref |=> cif.count == $past(act_ff[KWW_STS_RLD]))
        else $error("window change did not reload");
    a_early_reset: assert property (early |=> wdt_reset_req ##1 !wdt_reset_req)
        else $error("early refresh gave no single reset pulse");
    a_standby_keep: assert property (standby_rst && !cfg_wr[KWW_STS_RLD] && !cif.tick
                                     |=> pend_ff == $past(pend_ff) && act_ff[KWW_STS_RLD] == KWW_RST_RLD)
        else $error("standby reset handling wrong");
    a_start_runs: assert property (key_go |=> cif.running)
        else $error("start key did not start");

    c_unlock_write: cover property (key_unl ##[1:8] cfg_wr[KWW_STS_RLD]);
    c_refresh_ok: cover property (key_ref && cif.running && !early);
    c_early_hit: cover property (early);
    c_expire: cover property (cif.expired);

endmodule // kww_regs
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import kww_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, standby_rst, hw_wdt_en, pready, pslverr, wdt_reset_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        rd_err;
    int          err_total, n_checks, cyc, n, f;

    kww_regs dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_rst(standby_rst), .hw_wdt_en(hw_wdt_en),
        .wdt_reset_req(wdt_reset_req)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic summarize;
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd     = prdata;
        rd_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk32(rd, exp);
    endtask

    // pending flags clear within two divider periods, 512 cycles at most
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            apb(1'b0, KWW_OFF_STS, 32'h0000_0000, 4'h0);
            k++;
        end while (rd[2:0] !== 3'h0 && k < 200);
        chk32({29'h0, rd[2:0]}, 32'h0000_0000);
    endtask

    // cycles from now until the reset pulse, then the pulse must be gone
    task automatic measure;
        // a pulse seen at once is counted as n = 1, as an early refresh gives
        @(negedge pclk);
        n = 1;
        while (wdt_reset_req !== 1'b1 && n < 2000) begin
            @(negedge pclk);
            n++;
        end
        @(negedge pclk);
        chk32({31'h0, wdt_reset_req}, 32'h0000_0000);
    endtask

    initial begin
        cyc = 0;
        forever begin
            @(posedge pclk);
            cyc++;
            if (cyc > 40000) begin
                err_total++;
                summarize();
            end
        end
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, standby_rst, hw_wdt_en} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(KWW_OFF_KEY, 32'h0000_0000);
        rd_chk(KWW_OFF_DIV, 32'h0000_0000);
        rd_chk(KWW_OFF_RLD, 32'h0000_0fff);
        rd_chk(KWW_OFF_STS, 32'h0000_0000);
        rd_chk(KWW_OFF_WIN, 32'h0000_0fff);
        rd_chk(12'h014, 32'h0000_0000);
        chk32({31'h0, rd_err}, 32'h0000_0001);
        // locked: write ignored
        wr(KWW_OFF_RLD, 32'h0000_0004);
        rd_chk(KWW_OFF_RLD, 32'h0000_0fff);
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_UNLOCK});
        rd_chk(KWW_OFF_KEY, 32'h0000_0000);
        wr(KWW_OFF_RLD, 32'h0000_0004);
        // second write while flag pending is refused
        wr(KWW_OFF_RLD, 32'h0000_0020);
        rd_chk(KWW_OFF_STS, 32'h0000_0002);
        wait_idle();
        rd_chk(KWW_OFF_RLD, 32'h0000_0004);
        apb(1'b1, KWW_OFF_RLD, 32'h0000_0030, 4'h1);
        rd_chk(KWW_OFF_RLD, 32'h0000_0004);
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_REFRESH});
        wr(KWW_OFF_RLD, 32'h0000_0040);
        rd_chk(KWW_OFF_RLD, 32'h0000_0004);
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_START});
        // every divider code: timeout spans reload times factor cycles
        for (int c = 0; c < 8; c++) begin
            f = (c >= 6) ? 256 : (4 << c);
            wr(KWW_OFF_KEY, {16'h0, KWW_KEY_UNLOCK});
            wr(KWW_OFF_DIV, c);
            rd_chk(KWW_OFF_STS, 32'h0000_0001);
            wait_idle();
            rd_chk(KWW_OFF_DIV, c);
            wr(KWW_OFF_KEY, {16'h0, KWW_KEY_REFRESH});
            measure();
            chk32({31'h0, (n >= 3 * f && n <= 4 * f + 4)}, 32'h1);
        end
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_UNLOCK});
        wr(KWW_OFF_WIN, 32'h0000_0002);
        rd_chk(KWW_OFF_STS, 32'h0000_0004);
        wait_idle();
        rd_chk(KWW_OFF_WIN, 32'h0000_0002);
        // counter sits near reload 4, above window 2: refresh is early
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_REFRESH});
        measure();
        chk32({31'h0, (n <= 6)}, 32'h1);
        @(posedge pclk);
        standby_rst <= 1'b1;
        @(posedge pclk);
        standby_rst <= 1'b0;
        rd_chk(KWW_OFF_RLD, 32'h0000_0fff);
        rd_chk(KWW_OFF_WIN, 32'h0000_0fff);
        rd_chk(KWW_OFF_STS, 32'h0000_0000);
        rd_chk(KWW_OFF_DIV, 32'h0000_0007);
        wr(KWW_OFF_DIV, 32'h0000_0001);
        rd_chk(KWW_OFF_DIV, 32'h0000_0007);
        // mid-run reset with the hardware start option, no start key
        presetn   <= 1'b0;
        hw_wdt_en <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn   <= 1'b1;
        @(posedge pclk);
        hw_wdt_en <= 1'b0;
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_UNLOCK});
        wr(KWW_OFF_RLD, 32'h0000_0004);
        wait_idle();
        wr(KWW_OFF_KEY, {16'h0, KWW_KEY_REFRESH});
        measure();
        chk32({31'h0, (n >= 12 && n <= 20)}, 32'h1);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
